// [tmr8_params.svh]
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH
// register indices; byte address is four times the index
`define TMR8_IDX_CTL_TWO    8'h3c
`define TMR8_IDX_CTL_ONE    8'h3d
`define TMR8_IDX_FLAGS      8'h3e
`define TMR8_IDX_CAP_ONE    8'h3f
`define TMR8_IDX_CMP_ONE    8'h40
`define TMR8_IDX_CNT_MAIN   8'h41
`define TMR8_IDX_CNT_ALT    8'h42
`define TMR8_IDX_CAP_TWO    8'h43
`define TMR8_IDX_CMP_TWO    8'h44
// flag register bit positions
`define TMR8_BIT_CAP1       7
`define TMR8_BIT_CMP1       6
`define TMR8_BIT_OVF        5
`define TMR8_BIT_CAP2       4
`define TMR8_BIT_CMP2       3
`define TMR8_BIT_FREEZE     2
// control register bit positions
`define TMR8_BIT_OC1E       7
`define TMR8_BIT_OC2E       6
`define TMR8_BIT_PWM        4
`define TMR8_BIT_CC_LO      2
`define TMR8_BIT_IEDG2      1
`define TMR8_BIT_IEDG1      1
`define TMR8_BIT_OLVL2      2
`define TMR8_BIT_OLVL1      0
// reset values
`define TMR8_RST_CTL        8'h00
`define TMR8_RST_FLAGS      8'h00
`define TMR8_RST_CMP        8'h00
`define TMR8_RST_CNT        8'hfc
`define TMR8_CNT_MAX        8'hff
`define TMR8_CNT_ZERO       8'h00
// axi responses
`define TMR8_RESP_OKAY      2'b00
`define TMR8_RESP_SLVERR    2'b10
`endif

// [tmr8_pkg.sv]
package tmr8_pkg;
  typedef logic [7:0] tmr8_byte_t;
  typedef enum logic [2:0] {
    TMR8_BUS_IDLE = 3'b001,
    TMR8_BUS_WRESP = 3'b010,
    TMR8_BUS_RRESP = 3'b100
  } tmr8_bus_e;
endpackage

// [tmr8_timer.sv]
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "tmr8_params.svh"
// Contract
// [R1] capture pin one or pwm period sets bit7
// [R2] bit7 clears on status read then capture-one access
// [R3] counter equals compare one sets bit6
// [R4] counter wrap sets bit5, cleared via main counter
// [R5] alternate counter access never clears overflow
// [R6] capture pin two sets bit4, cleared via capture two
// [R7] counter equals compare two sets bit3
// [R8] freeze bit stops prescaler, counter, compare pins
// [R9] registers stay accessible while frozen
// [R10] status resets zero, only bit2 writable
// [R11] capture one copies counter, read only
// [R12] capture two copies counter, read only
// [R13] compare registers reset zero, read write
// [R14] counters reset to fch, read live value
// [R15] write to either counter resets counter
// [R16] status read arms flag; data access clears
// [R17] counter increments per tick, wraps to zero
module tmr8_timer (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // timer pins
  input  wire logic        capture_pin_one,
  input  wire logic        capture_pin_two,
  output logic             compare_pin_one,
  output logic             compare_pin_two,
  output logic             compare_pin_one_en,
  output logic             compare_pin_two_en
);

  // index decode: byte address must be aligned and map to a register index
  function automatic logic [8:0] idx_of(input logic [11:0] a);
    idx_of = {(a[1:0] != 2'b00) || (a[11:10] != 2'b00), a[9:2]};
  endfunction

  tmr8_pkg::tmr8_bus_e  bus_q;
  tmr8_pkg::tmr8_byte_t ctl_one_q, ctl_two_q, cmp_one_q, cmp_two_q;
  tmr8_pkg::tmr8_byte_t cap_one_q, cap_two_q, cnt_q;
  logic [11:0] aw_q;
  logic        aw_have_q, w_have_q;
  logic [31:0] wd_q;
  logic        freeze_q;
  logic [4:0]  flag_q;   // cap1,cmp1,ovf,cap2,cmp2
  logic [4:0]  arm_q;
  logic [2:0]  pre_q;
  logic [1:0]  c1_s_q, c2_s_q;
  logic        c1_d_q, c2_d_q;
  logic        aw_ready_q, w_ready_q, ar_ready_q;
  logic        pin1_q, pin2_q;

  // bus strobes
  logic        wr_go, rd_go, wr_hit, rd_hit;
  logic [8:0]  wr_idx, rd_idx;
  assign wr_go  = (bus_q == tmr8_pkg::TMR8_BUS_IDLE) && aw_have_q && w_have_q;
  assign rd_go  = (bus_q == tmr8_pkg::TMR8_BUS_IDLE) && !wr_go && s_axi_arvalid;
  assign wr_idx = idx_of(aw_q);
  assign rd_idx = idx_of(s_axi_araddr);
  assign wr_hit = wr_go && (wr_idx >= {1'b0, `TMR8_IDX_CTL_TWO})
                        && (wr_idx <= {1'b0, `TMR8_IDX_CMP_TWO});
  assign rd_hit = rd_go && (rd_idx >= {1'b0, `TMR8_IDX_CTL_TWO})
                        && (rd_idx <= {1'b0, `TMR8_IDX_CMP_TWO});

  // per-register access strobes (read or write)
  function automatic logic acc(input logic [8:0] i);
    acc = (wr_go && wr_idx == i) || (rd_go && rd_idx == i);
  endfunction
  logic [3:0] wstrb_q;
  logic       s_axi_wstrb_q0;
  logic       wr_en0;
  assign s_axi_wstrb_q0 = wstrb_q[0];
  assign wr_en0 = wr_go && s_axi_wstrb_q0;

  // prescaler tick, clock control selects /4, /2, /8, /8 (slow source not modeled)
  logic tick;
  always_comb begin
    case (ctl_two_q[`TMR8_BIT_CC_LO +: 2])
      2'b00:   tick = pre_q[1:0] == 2'b11;
      2'b01:   tick = pre_q[0];
      default: tick = pre_q == 3'b111;
    endcase
  end

  logic run;
  assign run = !freeze_q; // [R8]

  // input synchronisers and edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c1_s_q <= 2'b00;
      c2_s_q <= 2'b00;
      c1_d_q <= 1'b0;
      c2_d_q <= 1'b0;
    end else begin
      c1_s_q <= {c1_s_q[0], capture_pin_one};
      c2_s_q <= {c2_s_q[0], capture_pin_two};
      c1_d_q <= c1_s_q[1];
      c2_d_q <= c2_s_q[1];
    end
  end
  logic cap1_ev, cap2_ev, pwm_mode, cmp1_ev, cmp2_ev, ovf_ev, cnt_wr;
  assign pwm_mode = ctl_two_q[`TMR8_BIT_PWM];
  assign cap1_ev = ctl_one_q[`TMR8_BIT_IEDG1] ? (c1_s_q[1] && !c1_d_q)
                                              : (!c1_s_q[1] && c1_d_q);
  assign cap2_ev = ctl_two_q[`TMR8_BIT_IEDG2] ? (c2_s_q[1] && !c2_d_q)
                                              : (!c2_s_q[1] && c2_d_q);
  assign cmp1_ev = run && tick && (cnt_q == cmp_one_q);
  assign cmp2_ev = run && tick && (cnt_q == cmp_two_q);
  assign ovf_ev  = run && tick && (cnt_q == `TMR8_CNT_MAX);
  assign cnt_wr  = wr_go && (wr_idx == {1'b0, `TMR8_IDX_CNT_MAIN} ||
                             wr_idx == {1'b0, `TMR8_IDX_CNT_ALT});

  // prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 3'b000;
    end else if (run) begin // [R8]
      pre_q <= pre_q + 3'b001;
    end
  end

  // free-running counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= `TMR8_RST_CNT; // [R14]
    end else if (cnt_wr) begin
      cnt_q <= `TMR8_RST_CNT; // [R15]
    end else if (run && tick) begin
      if (pwm_mode && cnt_q == cmp_two_q) begin
        cnt_q <= `TMR8_RST_CNT;
      end else begin
        cnt_q <= cnt_q + 8'h01; // [R17]
      end
    end
  end

  // capture registers, no reset value
  always_ff @(posedge aclk) begin
    if (cap1_ev) begin
      cap_one_q <= cnt_q; // [R11]
    end
    if (cap2_ev) begin
      cap_two_q <= cnt_q; // [R12]
    end
  end

  // flags: set wins over clear
  logic [4:0] set_v, clr_v, acc_v;
  assign set_v = {(cap1_ev && !pwm_mode) || (cmp2_ev && pwm_mode), // [R1]
                  cmp1_ev && !pwm_mode,                            // [R3]
                  ovf_ev,                                          // [R4]
                  cap2_ev,                                         // [R6]
                  cmp2_ev && !pwm_mode};                           // [R7]
  assign acc_v = {acc({1'b0, `TMR8_IDX_CAP_ONE}),  // [R2]
                  acc({1'b0, `TMR8_IDX_CMP_ONE}),
                  acc({1'b0, `TMR8_IDX_CNT_MAIN}), // [R5]
                  acc({1'b0, `TMR8_IDX_CAP_TWO}),
                  acc({1'b0, `TMR8_IDX_CMP_TWO})};
  assign clr_v = arm_q & acc_v;
  logic st_rd;
  assign st_rd = rd_go && rd_idx == {1'b0, `TMR8_IDX_FLAGS};
  logic alt_acc;
  assign alt_acc = acc({1'b0, `TMR8_IDX_CNT_ALT});
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 5'b00000; // [R10]
      arm_q  <= 5'b00000;
    end else begin
      flag_q <= (flag_q & ~clr_v) | set_v;
      arm_q  <= (arm_q & ~clr_v) | (st_rd ? flag_q : 5'b00000); // [R16]
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_one_q <= `TMR8_RST_CTL;
      ctl_two_q <= `TMR8_RST_CTL;
      cmp_one_q <= `TMR8_RST_CMP; // [R13]
      cmp_two_q <= `TMR8_RST_CMP;
      freeze_q  <= 1'b0;
    end else if (wr_en0) begin // [R9]
      case (wr_idx)
        {1'b0, `TMR8_IDX_CTL_ONE}: ctl_one_q <= wd_q[7:0];
        {1'b0, `TMR8_IDX_CTL_TWO}: ctl_two_q <= {wd_q[7:1], 1'b0};
        {1'b0, `TMR8_IDX_CMP_ONE}: cmp_one_q <= wd_q[7:0];
        {1'b0, `TMR8_IDX_CMP_TWO}: cmp_two_q <= wd_q[7:0];
        {1'b0, `TMR8_IDX_FLAGS}:   freeze_q  <= wd_q[`TMR8_BIT_FREEZE]; // [R10]
        default: ;
      endcase
    end
  end

  // compare pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin1_q <= 1'b0;
      pin2_q <= 1'b0;
      compare_pin_one_en <= 1'b0;
      compare_pin_two_en <= 1'b0;
    end else begin
      if (pwm_mode && run && tick && cnt_q == cmp_one_q) begin
        pin1_q <= ctl_one_q[`TMR8_BIT_OLVL2];
      end else if (pwm_mode && run && tick && cnt_q == cmp_two_q) begin
        pin1_q <= ctl_one_q[`TMR8_BIT_OLVL1];
      end else if (cmp1_ev && !pwm_mode) begin
        pin1_q <= ctl_one_q[`TMR8_BIT_OLVL1];
      end
      if (cmp2_ev && !pwm_mode) begin
        pin2_q <= ctl_one_q[`TMR8_BIT_OLVL2];
      end
      compare_pin_one_en <= ctl_two_q[`TMR8_BIT_OC1E] && run; // [R8]
      compare_pin_two_en <= ctl_two_q[`TMR8_BIT_OC2E] && run; // [R8]
    end
  end
  assign compare_pin_one = pin1_q;
  assign compare_pin_two = pin2_q;

  // read mux
  logic [7:0] rd_v;
  always_comb begin
    case (rd_idx)
      {1'b0, `TMR8_IDX_CTL_ONE}:  rd_v = ctl_one_q;
      {1'b0, `TMR8_IDX_CTL_TWO}:  rd_v = ctl_two_q;
      {1'b0, `TMR8_IDX_FLAGS}:    rd_v = {flag_q, freeze_q, 2'b00};
      {1'b0, `TMR8_IDX_CAP_ONE}:  rd_v = cap_one_q;
      {1'b0, `TMR8_IDX_CMP_ONE}:  rd_v = cmp_one_q;
      {1'b0, `TMR8_IDX_CNT_MAIN}: rd_v = cnt_q; // [R14]
      {1'b0, `TMR8_IDX_CNT_ALT}:  rd_v = cnt_q; // [R14]
      {1'b0, `TMR8_IDX_CAP_TWO}:  rd_v = cap_two_q;
      {1'b0, `TMR8_IDX_CMP_TWO}:  rd_v = cmp_two_q;
      default:                    rd_v = 8'h00;
    endcase
  end

  // axi4-lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_q <= tmr8_pkg::TMR8_BUS_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 12'h000;
      wd_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      aw_ready_q <= 1'b0;
      w_ready_q <= 1'b0;
      ar_ready_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TMR8_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `TMR8_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      aw_ready_q <= 1'b0;
      w_ready_q <= 1'b0;
      ar_ready_q <= 1'b0;
      if (s_axi_awvalid && !aw_have_q && !aw_ready_q && bus_q == tmr8_pkg::TMR8_BUS_IDLE) begin
        aw_ready_q <= 1'b1;
      end
      if (aw_ready_q && s_axi_awvalid) begin
        aw_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && !w_have_q && !w_ready_q && bus_q == tmr8_pkg::TMR8_BUS_IDLE) begin
        w_ready_q <= 1'b1;
      end
      if (w_ready_q && s_axi_wvalid) begin
        wd_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      case (bus_q)
        tmr8_pkg::TMR8_BUS_IDLE: begin
          if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `TMR8_RESP_OKAY : `TMR8_RESP_SLVERR;
            bus_q <= tmr8_pkg::TMR8_BUS_WRESP;
          end else if (rd_go) begin
            ar_ready_q <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_v};
            s_axi_rresp <= rd_hit ? `TMR8_RESP_OKAY : `TMR8_RESP_SLVERR;
            bus_q <= tmr8_pkg::TMR8_BUS_RRESP;
          end
        end
        tmr8_pkg::TMR8_BUS_WRESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            bus_q <= tmr8_pkg::TMR8_BUS_IDLE;
          end
        end
        tmr8_pkg::TMR8_BUS_RRESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            bus_q <= tmr8_pkg::TMR8_BUS_IDLE;
          end
        end
        default: bus_q <= tmr8_pkg::TMR8_BUS_IDLE;
      endcase
    end
  end
  assign s_axi_awready = aw_ready_q;
  assign s_axi_wready  = w_ready_q;
  assign s_axi_arready = ar_ready_q;

  // checks
  chk_ovf_sets: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    ovf_ev |=> flag_q[2]) else $error("overflow flag not set");
  chk_cap1_sets: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    (cap1_ev && !pwm_mode) |=> flag_q[4] && cap_one_q == $past(cnt_q))
    else $error("capture one missed");
  chk_cap2_sets: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    cap2_ev |=> flag_q[1] && cap_two_q == $past(cnt_q)) else $error("capture two missed");
  chk_cmp1_sets: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    (cmp1_ev && !pwm_mode) |=> flag_q[3]) else $error("compare one flag missed");
  chk_cmp2_sets: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    (cmp2_ev && !pwm_mode) |=> flag_q[0]) else $error("compare two flag missed");
  chk_freeze_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    (freeze_q && !cnt_wr) |=> cnt_q == $past(cnt_q)) else $error("counter moved while frozen");
  chk_cnt_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
    cnt_wr |=> cnt_q == `TMR8_RST_CNT) else $error("counter write did not reset");
  chk_alt_keeps: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    (alt_acc && flag_q[2]) |=> flag_q[2]) else $error("alt cleared ovf");
  chk_no_arm_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
    (flag_q[4] && !arm_q[4]) |=> flag_q[4]) else $error("flag cleared without status read");
  chk_cnt_step: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
    (run && tick && !cnt_wr && !pwm_mode) |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter step wrong");

  // clear steps: armed by a status read, then the data register access
  sequence s_cap1_clear;
    arm_q[4] && acc_v[4] && !set_v[4];
  endsequence
  sequence s_ovf_clear;
    arm_q[2] && acc_v[2] && !set_v[2];
  endsequence
  sequence s_ovf_arm;
    st_rd && flag_q[2];
  endsequence
  chk_cap1_clears: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    s_cap1_clear |=> !flag_q[4]) else $error("capture one flag not cleared");
  chk_ovf_clears: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    s_ovf_clear |=> !flag_q[2]) else $error("overflow flag not cleared");
  chk_ovf_arms: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
    s_ovf_arm |=> arm_q[2]) else $error("status read did not arm flag");
  chk_pwm_period: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    (cmp2_ev && pwm_mode) |=> flag_q[4] && cnt_q == `TMR8_RST_CNT)
    else $error("pwm period not flagged");
  chk_freeze_pins: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    freeze_q |=> !compare_pin_one_en && !compare_pin_two_en)
    else $error("compare pins live while frozen");
  chk_cnt_reset: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    $rose(aresetn) |-> cnt_q == `TMR8_RST_CNT && flag_q == 5'b00000)
    else $error("reset values wrong");
endmodule

// [tmr8_tb.sv]
`timescale 1ns/100ps
`include "tmr8_params.svh"
module testbench;
  logic        aclk;
  logic        aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        capture_pin_one, capture_pin_two;
  logic        compare_pin_one, compare_pin_two, compare_pin_one_en, compare_pin_two_en;
  int          mismatches;
  int          compares;
  localparam logic [11:0] A_CT2 = {2'b00, `TMR8_IDX_CTL_TWO, 2'b00};
  localparam logic [11:0] A_CT1 = {2'b00, `TMR8_IDX_CTL_ONE, 2'b00};
  localparam logic [11:0] A_FLG = {2'b00, `TMR8_IDX_FLAGS, 2'b00};
  localparam logic [11:0] A_CP1 = {2'b00, `TMR8_IDX_CAP_ONE, 2'b00};
  localparam logic [11:0] A_OC1 = {2'b00, `TMR8_IDX_CMP_ONE, 2'b00};
  localparam logic [11:0] A_CNT = {2'b00, `TMR8_IDX_CNT_MAIN, 2'b00};
  localparam logic [11:0] A_ALT = {2'b00, `TMR8_IDX_CNT_ALT, 2'b00};
  localparam logic [11:0] A_CP2 = {2'b00, `TMR8_IDX_CAP_TWO, 2'b00};
  localparam logic [11:0] A_OC2 = {2'b00, `TMR8_IDX_CMP_TWO, 2'b00};
  localparam logic [1:0]  OK    = `TMR8_RESP_OKAY;
  localparam logic [1:0]  ERR   = `TMR8_RESP_SLVERR;

  tmr8_timer i_tmr8_timer (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
    .compare_pin_one(compare_pin_one), .compare_pin_two(compare_pin_two),
    .compare_pin_one_en(compare_pin_one_en), .compare_pin_two_en(compare_pin_two_en)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task end_of_test;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task expired;
    chk(32'h0, 32'h1);
    end_of_test();
  endtask

  // write one byte, compare the response code
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        break;
      end
    end
    if (n == 100) expired();
  endtask

  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 100) expired();
  endtask

  task rc(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk({30'h0, r}, {30'h0, OK});
    chk(d, {24'h000000, e});
  endtask

  task t_reset;
    wr(A_FLG, 8'h04, OK);
    rc(A_FLG, 8'h04);
    rc(A_OC1, `TMR8_RST_CMP);
    rc(A_OC2, `TMR8_RST_CMP);
    wr(A_CNT, 8'h5a, OK);
    rc(A_CNT, `TMR8_RST_CNT);
    rc(A_ALT, `TMR8_RST_CNT);
    wr(A_OC1, 8'ha5, OK);
    rc(A_OC1, 8'ha5);
    $display("test reset values done");
  endtask

  task t_flags;
    logic [31:0] d;
    logic [31:0] v;
    logic [1:0]  r;
    int          n;
    wr(A_OC1, 8'hfd, OK);
    wr(A_OC2, 8'hfe, OK);
    wr(A_CT2, 8'hc2, OK);
    wr(A_CT1, 8'h07, OK);
    wr(A_ALT, 8'h00, OK);
    wr(A_FLG, 8'h00, OK);
    for (n = 0; n < 60; n++) begin
      rd(A_ALT, d, r);
      if (d[7:0] >= 8'h01 && d[7:0] <= 8'h20) break;
    end
    if (n == 60) expired();
    chk({30'h0, compare_pin_one_en, compare_pin_two_en}, 32'h3);
    chk({30'h0, compare_pin_one, compare_pin_two}, 32'h3);
    wr(A_FLG, 8'h04, OK);
    repeat (3) @(posedge aclk);
    chk({30'h0, compare_pin_one_en, compare_pin_two_en}, 32'h0);
    rd(A_ALT, v, r);
    repeat (12) @(posedge aclk);
    rd(A_ALT, d, r);
    chk(d, v);
    rc(A_OC1, 8'hfd);
    rc(A_FLG, 8'h6c);
    rd(A_ALT, d, r);
    rc(A_FLG, 8'h6c);
    rd(A_CNT, d, r);
    rc(A_FLG, 8'h4c);
    rc(A_OC1, 8'hfd);
    rc(A_FLG, 8'h0c);
    wr(A_OC2, 8'hfe, OK);
    rc(A_FLG, 8'h04);
    $display("test flags done");
  endtask

  task t_capture(input bit two);
    logic [31:0] d;
    logic [31:0] v;
    logic [1:0]  r;
    int          n;
    rd(A_ALT, v, r);
    if (two) capture_pin_two <= 1'b1;
    else capture_pin_one <= 1'b1;
    for (n = 0; n < 30; n++) begin
      rd(A_FLG, d, r);
      if (d[two ? `TMR8_BIT_CAP2 : `TMR8_BIT_CAP1] === 1'b1) break;
    end
    if (n == 30) expired();
    chk(d, two ? 32'h14 : 32'h84);
    rc(two ? A_CP2 : A_CP1, v[7:0]);
    rc(A_FLG, 8'h04);
    wr(two ? A_CP2 : A_CP1, 8'h33, OK);
    rc(two ? A_CP2 : A_CP1, v[7:0]);
    capture_pin_one <= 1'b0;
    capture_pin_two <= 1'b0;
    $display("test capture done");
  endtask

  task t_errors;
    logic [31:0] d;
    logic [1:0]  r;
    wr(A_FLG, 8'hfc, OK);
    rc(A_FLG, 8'h04);
    rc(A_CT2, 8'hc2);
    rd(12'h000, d, r);
    chk({30'h0, r}, {30'h0, ERR});
    chk(d, 32'h0);
    rd(A_FLG + 12'h001, d, r);
    chk({30'h0, r}, {30'h0, ERR});
    chk(d, 32'h0);
    rd(A_FLG + 12'h400, d, r);
    chk({30'h0, r}, {30'h0, ERR});
    chk(d, 32'h0);
    wr(12'h000, 8'h11, ERR);
    $display("test read only and errors done");
  endtask

  // pwm at /2: pin one goes high at compare one, low at the period match
  task t_pwm;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(A_OC1, 8'h02, OK);
    wr(A_OC2, 8'h05, OK);
    wr(A_CT1, 8'h06, OK);
    wr(A_CT2, 8'hd6, OK);
    wr(A_ALT, 8'h00, OK);
    wr(A_FLG, 8'h00, OK);
    for (n = 0; n < 40; n++) begin
      rd(A_FLG, d, r);
      if (d[`TMR8_BIT_CAP1] === 1'b1) break;
    end
    if (n == 40) expired();
    chk(d, 32'ha0);
    chk({31'h0, compare_pin_one}, 32'h0);
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (compare_pin_one === 1'b1) break;
    end
    if (n == 40) expired();
    chk({31'h0, compare_pin_one}, 32'h1);
    wr(A_FLG, 8'h04, OK);
    $display("test pwm done");
  endtask

  initial begin
    mismatches = 0;
    compares = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    capture_pin_one = 1'b0;
    capture_pin_two = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_flags();
    t_capture(1'b0);
    t_capture(1'b1);
    t_errors();
    t_pwm();
    end_of_test();
  end
endmodule
